// File: hw/pfm_consts.vh
// Constants for the port function multiplexer
`ifndef PFM_CONSTS_VH
`define PFM_CONSTS_VH

// Upper address halves of the two register windows
`define PFM_BASE_CPU_HI 16'h4001
`define PFM_BASE_EXT_HI 16'h000d

// Register offsets inside one port block
`define PFM_OFS_MODE    3'h0
`define PFM_OFS_DIR     3'h1
`define PFM_OFS_FSEL    3'h2
`define PFM_OFS_FEXP    3'h3
`define PFM_OFS_DOUT    3'h4
`define PFM_OFS_DIN     3'h5
`define PFM_OFS_LAST    3'h5

// Address fields: port block stride 32 bytes
`define PFM_ADR_PORT_LSB 5
`define PFM_ADR_REG_LSB  2

// Reset values
`define PFM_RST_MODE 8'h00
`define PFM_RST_DIR  8'hff
`define PFM_RST_FSEL 8'h00
`define PFM_RST_FEXP 8'h00
`define PFM_RST_DOUT 8'h00

// AXI responses
`define PFM_RESP_OKAY   2'h0
`define PFM_RESP_DECERR 2'h3

// Pin indices, port*8 + bit
`define PFM_PIN_P13 11
`define PFM_PIN_P20 16
`define PFM_PIN_P26 22
`define PFM_PIN_P35 29
`define PFM_PIN_P50 40
`define PFM_PIN_P51 41
`define PFM_PIN_P62 50
`define PFM_PIN_P70 56

// Function codes {expand, select}
`define PFM_FN1 2'h0
`define PFM_FN2 2'h1
`define PFM_FN3 2'h2
`define PFM_FN4 2'h3
`define PFM_FN_COMM 2'h0

`endif

// File: hw/pfm_port_function_mux.v
// Port function multiplexer with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`include "pfm_consts.vh"
`default_nettype none

module pfm_port_function_mux #(
   parameter NPORT = 8
) (
   input  wire                 i_ref_clk,
   input  wire                 i_srst,
   // AXI4-Lite slave
   input  wire [31:0]          i_s_axi_awaddr,
   input  wire                 i_s_axi_awvalid,
   output wire                 o_s_axi_awready,
   input  wire [31:0]          i_s_axi_wdata,
   input  wire [3:0]           i_s_axi_wstrb,
   input  wire                 i_s_axi_wvalid,
   output wire                 o_s_axi_wready,
   output reg  [1:0]           o_s_axi_bresp,
   output reg                  o_s_axi_bvalid,
   input  wire                 i_s_axi_bready,
   input  wire [31:0]          i_s_axi_araddr,
   input  wire                 i_s_axi_arvalid,
   output wire                 o_s_axi_arready,
   output reg  [31:0]          o_s_axi_rdata,
   output reg  [1:0]           o_s_axi_rresp,
   output reg                  o_s_axi_rvalid,
   input  wire                 i_s_axi_rready,
   // Pins
   input  wire [NPORT*8-1:0]   i_pin_in,
   output reg  [NPORT*8-1:0]   o_pin_out,
   output reg  [NPORT*8-1:0]   o_pin_oe,
   // Generic peripheral functions, slot fn*NPIN+pin
   input  wire [NPORT*32-1:0]  i_fn_out,
   input  wire [NPORT*32-1:0]  i_fn_oe,
   output reg  [NPORT*8-1:0]   o_fn_in,
   // Communications circuit
   input  wire                 i_comm_irq_out_n,
   input  wire                 i_link_error_led_n,
   input  wire                 i_run_led_n,
   input  wire                 i_link_run_led_n,
   input  wire                 i_rx_data_led_n,
   output reg                  o_ext_irq22_in,
   output reg                  o_comm_wdt_error_in_n,
   output reg  [7:0]           o_station_number_in,
   output reg  [3:0]           o_transfer_rate_in
);

   localparam NPIN = NPORT * 8;

   reg  [NPIN-1:0]   mode_q;
   reg  [NPIN-1:0]   dir_q;
   reg  [NPIN-1:0]   fsel_q;
   reg  [NPIN-1:0]   fexp_q;
   reg  [NPIN-1:0]   dout_q;
   reg  [NPIN-1:0]   sync_a_q;
   reg  [NPIN-1:0]   sync_b_q;
   reg  [4*NPIN-1:0] fo;
   reg  [4*NPIN-1:0] foe;
   wire [NPIN-1:0]   pin_out_d;
   wire [NPIN-1:0]   pin_oe_d;

   reg  [31:0]       awaddr_q;
   reg  [31:0]       wdata_q;
   reg               wstrb0_q;
   reg               aw_got_q;
   reg               w_got_q;

   // Decode: window hit, in range, aligned
   function dec_ok;
      input [31:0] a;
      begin
         dec_ok = ((a[31:16] == `PFM_BASE_CPU_HI) ||
                   (a[31:16] == `PFM_BASE_EXT_HI)) &&
                  (a[15:8] == 8'h00) &&
                  (a[1:0] == 2'h0) &&
                  (a[7:5] < NPORT) &&
                  (a[4:2] <= `PFM_OFS_LAST);
      end
   endfunction

   // Write channel
   assign o_s_axi_awready = !aw_got_q && !o_s_axi_bvalid;
   assign o_s_axi_wready  = !w_got_q && !o_s_axi_bvalid;

   wire       do_wr   = aw_got_q && w_got_q && !o_s_axi_bvalid;
   wire       wr_ok   = dec_ok(awaddr_q);
   wire [2:0] wr_port = awaddr_q[7:5];
   wire [2:0] wr_reg  = awaddr_q[4:2];
   wire [7:0] wr_byte = wdata_q[7:0];

   always @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         awaddr_q       <= 32'h0000_0000;
         wdata_q        <= 32'h0000_0000;
         wstrb0_q       <= 1'b0;
         aw_got_q       <= 1'b0;
         w_got_q        <= 1'b0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp  <= `PFM_RESP_OKAY;
      end
      else
      begin
         if (i_s_axi_awvalid && o_s_axi_awready)
         begin
            awaddr_q <= i_s_axi_awaddr;
            aw_got_q <= 1'b1;
         end
         if (i_s_axi_wvalid && o_s_axi_wready)
         begin
            wdata_q  <= i_s_axi_wdata;
            wstrb0_q <= i_s_axi_wstrb[0];
            w_got_q  <= 1'b1;
         end
         if (do_wr)
         begin
            aw_got_q       <= 1'b0;
            w_got_q        <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= wr_ok ? `PFM_RESP_OKAY : `PFM_RESP_DECERR;
         end
         else if (o_s_axi_bvalid && i_s_axi_bready)
         begin
            o_s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register file; only byte lane 0 carries data
   always @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         mode_q <= {NPORT{`PFM_RST_MODE}};
         dir_q  <= {NPORT{`PFM_RST_DIR}};
         fsel_q <= {NPORT{`PFM_RST_FSEL}};
         fexp_q <= {NPORT{`PFM_RST_FEXP}};
         dout_q <= {NPORT{`PFM_RST_DOUT}};
      end
      else if (do_wr && wr_ok && wstrb0_q)
      begin
         case (wr_reg)
            `PFM_OFS_MODE: mode_q[wr_port*8 +: 8] <= wr_byte;
            `PFM_OFS_DIR:  dir_q[wr_port*8 +: 8]  <= wr_byte;
            `PFM_OFS_FSEL: fsel_q[wr_port*8 +: 8] <= wr_byte;
            `PFM_OFS_FEXP: fexp_q[wr_port*8 +: 8] <= wr_byte;
            `PFM_OFS_DOUT: dout_q[wr_port*8 +: 8] <= wr_byte;
            default:
            begin
               // Input register is read only
            end
         endcase
      end
   end

   // Read channel
   assign o_s_axi_arready = !o_s_axi_rvalid;

   wire [2:0] rd_port = i_s_axi_araddr[7:5];
   reg  [7:0] rd_byte;

   always @*
   begin
      rd_byte = 8'h00;
      case (i_s_axi_araddr[4:2])
         `PFM_OFS_MODE: rd_byte = mode_q[rd_port*8 +: 8];
         `PFM_OFS_DIR:  rd_byte = dir_q[rd_port*8 +: 8];
         `PFM_OFS_FSEL: rd_byte = fsel_q[rd_port*8 +: 8];
         `PFM_OFS_FEXP: rd_byte = fexp_q[rd_port*8 +: 8];
         `PFM_OFS_DOUT: rd_byte = dout_q[rd_port*8 +: 8];
         `PFM_OFS_DIN:  rd_byte = sync_b_q[rd_port*8 +: 8];
         default:       rd_byte = 8'h00;
      endcase
   end

   always @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata  <= 32'h0000_0000;
         o_s_axi_rresp  <= `PFM_RESP_OKAY;
      end
      else if (i_s_axi_arvalid && o_s_axi_arready)
      begin
         o_s_axi_rvalid <= 1'b1;
         if (dec_ok(i_s_axi_araddr))
         begin
            o_s_axi_rdata <= {24'h00_0000, rd_byte};
            o_s_axi_rresp <= `PFM_RESP_OKAY;
         end
         else
         begin
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= `PFM_RESP_DECERR;
         end
      end
      else if (o_s_axi_rvalid && i_s_axi_rready)
      begin
         o_s_axi_rvalid <= 1'b0;
      end
   end

   // Dedicated communications signals replace their generic slots
   always @*
   begin
      fo  = i_fn_out;
      foe = i_fn_oe;
      fo[2*NPIN+`PFM_PIN_P35]  = i_comm_irq_out_n;
      foe[2*NPIN+`PFM_PIN_P35] = 1'b1;
      // No function 4 here; keep the pin quiet if chosen
      foe[3*NPIN+`PFM_PIN_P35] = 1'b0;
      fo[`PFM_PIN_P20]  = i_link_error_led_n;
      foe[`PFM_PIN_P20] = 1'b1;
      fo[`PFM_PIN_P26]  = i_run_led_n;
      foe[`PFM_PIN_P26] = 1'b1;
      fo[`PFM_PIN_P50]  = i_link_run_led_n;
      foe[`PFM_PIN_P50] = 1'b1;
      fo[`PFM_PIN_P51]  = i_rx_data_led_n;
      foe[`PFM_PIN_P51] = 1'b1;
   end

   // Per pin selection
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1)
      begin : g_pin
         wire [1:0] fn = {fexp_q[gi], fsel_q[gi]};
         assign pin_out_d[gi] = mode_q[gi] ? fo[fn*NPIN+gi]
                                           : dout_q[gi];
         assign pin_oe_d[gi]  = mode_q[gi] ? foe[fn*NPIN+gi]
                                           : !dir_q[gi];
      end
   endgenerate

   function [1:0] fn_of;
      input integer p;
      begin
         fn_of = {fexp_q[p], fsel_q[p]};
      end
   endfunction

   // Pin drive; reset state is undriven so pull-ups hold high
   always @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_pin_out <= {NPIN{1'b1}};
         o_pin_oe  <= {NPIN{1'b0}};
      end
      else
      begin
         o_pin_out <= pin_out_d;
         o_pin_oe  <= pin_oe_d;
      end
   end

   // Pin inputs pass two flops before any use
   always @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         sync_a_q <= {NPIN{1'b1}};
         sync_b_q <= {NPIN{1'b1}};
      end
      else
      begin
         sync_a_q <= i_pin_in;
         sync_b_q <= sync_a_q;
      end
   end

   wire st_en = (mode_q[`PFM_PIN_P70 +: 8] == 8'hff) &&
                (fexp_q[`PFM_PIN_P70 +: 8] == 8'h00) &&
                (fsel_q[`PFM_PIN_P70 +: 8] == 8'h00);

   // Functional inputs; idle levels when not in control mode, except the transfer rate pins
   always @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_fn_in               <= {NPIN{1'b0}};
         o_ext_irq22_in        <= 1'b1;
         o_comm_wdt_error_in_n <= 1'b1;
         o_station_number_in   <= 8'h00;
         o_transfer_rate_in    <= 4'h0;
      end
      else
      begin
         o_fn_in <= sync_b_q & mode_q;
         o_ext_irq22_in <= (mode_q[`PFM_PIN_P35] &&
                            fn_of(`PFM_PIN_P35) == `PFM_FN2) ?
                           sync_b_q[`PFM_PIN_P35] : 1'b1;
         // Error seen only in control mode; active low
         o_comm_wdt_error_in_n <= (mode_q[`PFM_PIN_P13] &&
                                   fn_of(`PFM_PIN_P13) == `PFM_FN_COMM) ?
                                  sync_b_q[`PFM_PIN_P13] : 1'b1;
         o_station_number_in <= st_en ?
                                sync_b_q[`PFM_PIN_P70 +: 8] : 8'h00;
         // Rate pins read through even in port mode
         o_transfer_rate_in <= sync_b_q[`PFM_PIN_P62 +: 4];
      end
   end

endmodule // pfm_port_function_mux

`default_nettype wire

// File: bench/pfm_mux_asserts.sv
// Checker for the port function multiplexer
`include "pfm_consts.vh"
`default_nettype none
module pfm_mux_asserts #(parameter int NPORT = 8) (
   input wire logic               i_ref_clk,
   input wire logic               i_srst,
   input wire logic               i_s_axi_bready,
   input wire logic               o_s_axi_bvalid,
   input wire logic [1:0]         o_s_axi_bresp,
   input wire logic               i_s_axi_arvalid,
   input wire logic [31:0]        i_s_axi_araddr,
   input wire logic               o_s_axi_arready,
   input wire logic               i_s_axi_rready,
   input wire logic               o_s_axi_rvalid,
   input wire logic [31:0]        o_s_axi_rdata,
   input wire logic [1:0]         o_s_axi_rresp,
   input wire logic [NPORT*8-1:0] i_pin_in,
   input wire logic [NPORT*8-1:0] o_pin_out,
   input wire logic [NPORT*8-1:0] o_pin_oe,
   input wire logic               o_ext_irq22_in,
   input wire logic               o_comm_wdt_error_in_n,
   input wire logic [7:0]         o_station_number_in,
   input wire logic [3:0]         o_transfer_rate_in
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   // Pins quiet long enough for the sync chain to catch up
   sequence s_quiet;
      $stable(i_pin_in) [*5];
   endsequence
   sequence s_rd_take;
      i_s_axi_arvalid && o_s_axi_arready;
   endsequence
   chk_reset_hiz: assert property ($fell(i_srst) |-> o_pin_oe == 0 && &o_pin_out)
      else $error("pins driven after reset");
   chk_b_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
      o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped");
   chk_r_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
      o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read answer dropped");
   chk_ar_block: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
      else $error("read taken while busy");
   chk_rd_answer: assert property (s_rd_take |=> o_s_axi_rvalid)
      else $error("read not answered");
   chk_bad_base: assert property ((s_rd_take and !(i_s_axi_araddr[31:16] inside
      {`PFM_BASE_CPU_HI, `PFM_BASE_EXT_HI})) |=> o_s_axi_rresp == `PFM_RESP_DECERR
      && o_s_axi_rdata == 0) else $error("foreign base answered");
   chk_rate_sync: assert property (s_quiet |-> o_transfer_rate_in == i_pin_in[53:50])
      else $error("rate input stale");
   chk_station_in: assert property (s_quiet |->
      o_station_number_in inside {8'h00, i_pin_in[63:56]}) else $error("station input wrong");
   chk_wdt_path: assert property (s_quiet |-> o_comm_wdt_error_in_n
      || !i_pin_in[`PFM_PIN_P13]) else $error("watchdog input wrong");
   chk_irq_path: assert property (s_quiet |-> o_ext_irq22_in
      || !i_pin_in[`PFM_PIN_P35]) else $error("irq input wrong");
endmodule // pfm_mux_asserts
bind pfm_port_function_mux pfm_mux_asserts #(.NPORT(NPORT)) u_chk (.*);
`default_nettype wire

// File: bench/pfm_pin_model.sv
// Board model of the pins: device drive, outside drive, pull-up
`default_nettype none
module pfm_pin_model (
   input  wire logic [63:0] i_pad_out,
   input  wire logic [63:0] i_pad_oe,
   input  wire logic [63:0] i_ext_val,
   input  wire logic [63:0] i_ext_en,
   output logic      [63:0] o_pad
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pins read the outside drive if enabled, else the pull-up, never a held value
   assign o_pad = i_pad_oe & i_pad_out | ~i_pad_oe & (~i_ext_en | i_ext_val);
endmodule // pfm_pin_model
`default_nettype wire

// File: bench/port_function_mux_bench.sv
// Self-checking bench for the port function multiplexer
`include "pfm_consts.vh"
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module port_function_mux_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic         i_ref_clk = 0, i_srst = 1, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0;
   logic         i_s_axi_bready = 0, i_s_axi_arvalid = 0, i_s_axi_rready = 0;
   logic         i_comm_irq_out_n = 1, i_link_error_led_n = 1, i_run_led_n = 1;
   logic         i_link_run_led_n = 1, i_rx_data_led_n = 1, o_s_axi_awready, o_s_axi_wready;
   logic         o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_ext_irq22_in;
   logic         o_comm_wdt_error_in_n;
   logic [3:0]   i_s_axi_wstrb = 4'hf, o_transfer_rate_in;
   logic [31:0]  i_s_axi_awaddr = 0, i_s_axi_wdata = 0, i_s_axi_araddr = 0, o_s_axi_rdata, d;
   logic [31:0]  seed = 32'h4ac43416;
   logic [255:0] i_fn_out = 0, i_fn_oe = 0;
   logic [63:0]  ext_val = 0, ext_en = 0, i_pin_in, o_pin_out, o_pin_oe, o_fn_in;
   logic [1:0]   o_s_axi_bresp, o_s_axi_rresp, bq[$];
   logic [33:0]  rq[$];
   logic [7:0]   o_station_number_in;
   logic [7:0]   rv[6] = '{`PFM_RST_MODE, `PFM_RST_DIR, `PFM_RST_FSEL, `PFM_RST_FEXP,
                           `PFM_RST_DOUT, 8'hff};
   int           n_fail = 0, comparisons = 0;
   // Input-side function slots kept quiet so outside levels reach the pins
   localparam logic [255:0] OE_MASK = 256'hff << 56 | 256'h1 << 11 | 256'h1 << 93;
   pfm_port_function_mux #(.NPORT(8)) dut (.*);
   pfm_pin_model u_pins (.i_pad_out(o_pin_out), .i_pad_oe(o_pin_oe), .i_ext_val(ext_val),
                         .i_ext_en(ext_en), .o_pad(i_pin_in));
   always #12.5 i_ref_clk = ~i_ref_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] ad(input bit x, input int p, input logic [2:0] o);
      return {x ? `PFM_BASE_EXT_HI : `PFM_BASE_CPU_HI, 8'h00, p[2:0], o, 2'b00};
   endfunction
   task automatic close_out(input bit hung);
      n_fail += hung;
      $display("counts: %0d compared, %0d failed", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, dw, input logic [1:0] r = 2'h0);
      int n;
      bq.push_back(r);
      @(posedge i_ref_clk);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= dw;
      i_s_axi_awvalid <= 1;
      i_s_axi_wvalid <= 1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge i_ref_clk);
         if (o_s_axi_awready) i_s_axi_awvalid <= 0;
         if (o_s_axi_wready) i_s_axi_wvalid <= 0;
         if (o_s_axi_bvalid && i_s_axi_bready) break;
         i_s_axi_bready <= i_s_axi_bready | 1'(rnd());
      end
      i_s_axi_bready <= 0;
      if (n == 40) close_out(1);
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] dr, input logic [1:0] r = 2'h0);
      int n;
      rq.push_back({r, 24'h0, dr});
      @(posedge i_ref_clk);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge i_ref_clk);
         if (o_s_axi_arready) i_s_axi_arvalid <= 0;
         if (o_s_axi_rvalid && i_s_axi_rready) break;
         i_s_axi_rready <= i_s_axi_rready | 1'(rnd());
      end
      i_s_axi_rready <= 0;
      if (n == 40) close_out(1);
   endtask
   task automatic settle(input logic [63:0] v, e);
      @(posedge i_ref_clk);
      ext_val <= v;
      ext_en <= e;
      i_fn_out <= {8{rnd()}};
      i_fn_oe <= {8{rnd()}} & ~OE_MASK;
      {i_comm_irq_out_n, i_link_error_led_n, i_run_led_n, i_link_run_led_n,
       i_rx_data_led_n} <= 5'(rnd());
      repeat (5) @(posedge i_ref_clk);
      #1;
   endtask
   always @(posedge i_ref_clk)
   begin
      if (o_s_axi_bvalid && i_s_axi_bready) `CHK(o_s_axi_bresp, bq.pop_front())
      if (o_s_axi_rvalid && i_s_axi_rready) `CHK({o_s_axi_rresp, o_s_axi_rdata}, rq.pop_front())
   end
   initial
   begin
      repeat (16) @(posedge i_ref_clk);
      i_srst <= 0;
      #1;
      `CHK(o_pin_oe, 64'h0)
      for (int p = 0; p < 8; p++)
         for (int o = 0; o < 6; o++)
            rd(ad(p[0], p, o[2:0]), rv[o]);
      $display("test reset done");
      d = rnd();
      wr(ad(1, 1, `PFM_OFS_DIR), 32'h0000_0000);
      wr(ad(0, 1, `PFM_OFS_DOUT), d);
      settle(64'h0, 64'h0);
      `CHK({o_pin_oe[15:8], o_pin_out[15:8]}, {8'hff, d[7:0]})
      wr(ad(0, 1, `PFM_OFS_DIR), 32'h0000_00ff);
      wr(ad(1, 1, `PFM_OFS_DIN), ~d);
      settle({48'h0, d[15:8], 8'h0}, 64'hff00);
      rd(ad(0, 1, `PFM_OFS_DIN), d[15:8]);
      `CHK({o_pin_oe[15:8], o_fn_in[15:8]}, 16'h0000)
      $display("test port mode done");
      wr(ad(0, 3, `PFM_OFS_MODE), 32'h0000_0020);
      for (int f = 0; f < 3; f++)
      begin
         wr(ad(1, 3, `PFM_OFS_FSEL), {24'h00_0000, 2'b0, f[0], 5'h0});
         wr(ad(0, 3, `PFM_OFS_FEXP), {24'h00_0000, 2'b0, f[1], 5'h0});
         rd(ad(1, 3, `PFM_OFS_FSEL), {2'b0, f[0], 5'h0});
         rd(ad(0, 3, `PFM_OFS_FEXP), {2'b0, f[1], 5'h0});
         settle(64'h0, 64'h1 << 29);
         if (f == 2) `CHK({o_pin_oe[29], o_pin_out[29]}, {1'b1, i_comm_irq_out_n})
         else `CHK({o_pin_oe[29], o_pin_out[29]}, {i_fn_oe[f*64+29], i_fn_out[f*64+29]})
         `CHK(o_ext_irq22_in, f != 1)
      end
      $display("test functions done");
      wr(ad(0, 2, `PFM_OFS_MODE), 32'h0000_0041);
      wr(ad(1, 5, `PFM_OFS_MODE), 32'h0000_0003);
      wr(ad(0, 1, `PFM_OFS_MODE), 32'h0000_0008);
      wr(ad(1, 7, `PFM_OFS_MODE), 32'h0000_00ff);
      d = rnd();
      settle({d[7:0], 2'b00, d[11:8], 50'h0}, 64'hff3c_0000_0000_0800);
      `CHK(o_station_number_in, d[7:0])
      `CHK(o_fn_in[63:56], d[7:0])
      `CHK({o_transfer_rate_in, o_comm_wdt_error_in_n}, {d[11:8], 1'b0})
      `CHK({o_pin_out[16], o_pin_out[22], o_pin_out[40], o_pin_out[41], o_pin_oe[41]},
           {i_link_error_led_n, i_run_led_n, i_link_run_led_n, i_rx_data_led_n, 1'b1})
      $display("test comm pins done");
      rd(32'h4001_0100, 8'h00, `PFM_RESP_DECERR);
      rd(32'h4002_0000, 8'h00, `PFM_RESP_DECERR);
      rd(ad(0, 0, 3'h6), 8'h00, `PFM_RESP_DECERR);
      wr(32'h000e_0000, 32'h0000_0001, `PFM_RESP_DECERR);
      rd(ad(1, 0, `PFM_OFS_MODE), 8'h00);
      $display("test bad address done");
      close_out(0);
   end
endmodule // port_function_mux_bench
`default_nettype wire
